// [rtl/rsl_defines.svh]
`ifndef RSL_DEFINES_SVH
`define RSL_DEFINES_SVH
// register indices on the plain port
`define RSL_ADDR_CONFIG 3'h0
`define RSL_ADDR_STATUS 3'h1
`define RSL_ADDR_LATCH 3'h2
`define RSL_ADDR_IRQ_STATUS 3'h3
`define RSL_ADDR_IRQ_MASK 3'h4
`define RSL_ADDR_ACTUAL 3'h5
// switch_config fields
`define RSL_CFG_STOP_L 0
`define RSL_CFG_STOP_R 1
`define RSL_CFG_POL_L 2
`define RSL_CFG_POL_R 3
`define RSL_CFG_SWAP 4
`define RSL_CFG_LATCH_L_ACT 5
`define RSL_CFG_LATCH_L_INACT 6
`define RSL_CFG_LATCH_R_ACT 7
`define RSL_CFG_LATCH_R_INACT 8
`define RSL_CFG_WIDTH 12
`define RSL_CFG_RESET 12'h000
// ramp_switch_status fields
`define RSL_ST_STOP_L 0
`define RSL_ST_STOP_R 1
`define RSL_ST_LATCH_L 2
`define RSL_ST_LATCH_R 3
`define RSL_ST_EVT_STOP_L 4
`define RSL_ST_EVT_STOP_R 5
`define RSL_ST_ZEROWAIT 11
`define RSL_ST_SECOND 12
`define RSL_ST_STALL 13
`define RSL_ST_WIDTH 14
// interrupt bits
`define RSL_IRQ_LATCH_L 0
`define RSL_IRQ_LATCH_R 1
`define RSL_IRQ_SECOND 2
`define RSL_IRQ_STOP 3
`define RSL_IRQ_WIDTH 4
`define RSL_IRQ_RESET 4'h0
`endif

// [rtl/rsl_pkg.sv]
package rsl_pkg;
  typedef enum logic [2:0] {
    RSL_RUN = 3'b001,
    RSL_STOPPED = 3'b010,
    RSL_ZEROWAIT = 3'b100
  } rsl_motion_type;
endpackage

// [rtl/rsl_switch_sync.sv]
`timescale 1ns/1ps
module rsl_switch_sync (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // raw pin
  input wire logic i_pin,
  // synchronised level and previous sample
  output logic o_level,
  output logic o_prev
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign o_level = sync_q;
  assign o_prev = prev_q;
endmodule // rsl_switch_sync

// [rtl/rsl_zero_wait.sv]
`timescale 1ns/1ps
module rsl_zero_wait #(
  parameter int unsigned WAIT_WIDTH = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // control
  input wire logic i_start,
  input wire logic [WAIT_WIDTH-1:0] i_wait_cycles,
  // state
  output logic o_active
);
  logic [WAIT_WIDTH-1:0] count_q;
  logic active_q;
  initial begin
    if (WAIT_WIDTH < 1 || WAIT_WIDTH > 32) $error("bad WAIT_WIDTH");
  end
  // counts the post-stop standstill interval
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count_q <= '0;
      active_q <= 1'b0;
    end else if (i_start) begin
      count_q <= i_wait_cycles;
      active_q <= (i_wait_cycles != '0);
    end else if (active_q) begin
      count_q <= count_q - 1'b1;
      active_q <= (count_q > {{(WAIT_WIDTH-1){1'b0}}, 1'b1});
    end
  end
  assign o_active = active_q;
endmodule // rsl_zero_wait

// [rtl/rsl_ref_switch.sv]
`timescale 1ns/1ps
`include "rsl_defines.svh"
module rsl_ref_switch #(
  parameter int unsigned POS_WIDTH = 32,
  parameter int unsigned WAIT_WIDTH = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_rdata,
  // switch pins
  input wire logic i_left_switch_in,
  input wire logic i_right_switch_in,
  // ramp generator side
  input wire logic [POS_WIDTH-1:0] i_actual_position,
  input wire logic i_stall_indication,
  input wire logic i_second_move_event,
  input wire logic i_motion_request,
  input wire logic [WAIT_WIDTH-1:0] i_zero_wait_cycles,
  // motion control and interrupt
  output logic o_motor_hold,
  output logic o_irq
);
  import rsl_pkg::*;

  initial begin
    if (POS_WIDTH < 1 || POS_WIDTH > 32) $error("bad POS_WIDTH");
    if (WAIT_WIDTH < 1 || WAIT_WIDTH > 32) $error("bad WAIT_WIDTH");
  end

  logic [`RSL_CFG_WIDTH-1:0] switch_config_q;
  logic [POS_WIDTH-1:0] latched_position_q;
  logic latch_l_q;
  logic latch_r_q;
  logic second_q;
  logic [`RSL_IRQ_WIDTH-1:0] irq_status_q;
  logic [`RSL_IRQ_WIDTH-1:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic hold_q;
  logic irq_q;
  rsl_motion_type motion_q;
  logic [1:0] raw_lvl;
  logic [1:0] raw_prev;
  logic zw_active;

  // pin order for the per-side loop: left first, right second
  logic [1:0] raw_pin;
  assign raw_pin[0] = i_left_switch_in;
  assign raw_pin[1] = i_right_switch_in;

  // synchronise both pins before anything else
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      rsl_switch_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_pin(raw_pin[g]),
        .o_level(raw_lvl[g]),
        .o_prev(raw_prev[g])
      );
    end
  endgenerate

  // swap, then polarity, on current and previous samples
  logic swap;
  logic l_lvl;
  logic r_lvl;
  logic l_prv;
  logic r_prv;
  logic l_act;
  logic r_act;
  logic l_act_p;
  logic r_act_p;
  assign swap = switch_config_q[`RSL_CFG_SWAP];
  // swap exchanges the sides before polarity is applied
  always_comb begin
    if (swap) begin
      l_lvl = raw_lvl[1];
      r_lvl = raw_lvl[0];
      l_prv = raw_prev[1];
      r_prv = raw_prev[0];
    end else begin
      l_lvl = raw_lvl[0];
      r_lvl = raw_lvl[1];
      l_prv = raw_prev[0];
      r_prv = raw_prev[1];
    end
  end
  assign l_act = l_lvl ^ switch_config_q[`RSL_CFG_POL_L];
  assign l_act_p = l_prv ^ switch_config_q[`RSL_CFG_POL_L];
  assign r_act = r_lvl ^ switch_config_q[`RSL_CFG_POL_R];
  assign r_act_p = r_prv ^ switch_config_q[`RSL_CFG_POL_R];

  // latch triggers from consecutive samples
  logic l_rise;
  logic l_fall;
  logic r_rise;
  logic r_fall;
  logic fire_l;
  logic fire_r;
  logic fire_any;
  assign l_rise = l_act & ~l_act_p;
  assign l_fall = ~l_act & l_act_p;
  assign r_rise = r_act & ~r_act_p;
  assign r_fall = ~r_act & r_act_p;
  assign fire_l = (l_rise & switch_config_q[`RSL_CFG_LATCH_L_ACT])
    | (l_fall & switch_config_q[`RSL_CFG_LATCH_L_INACT]);
  assign fire_r = (r_rise & switch_config_q[`RSL_CFG_LATCH_R_ACT])
    | (r_fall & switch_config_q[`RSL_CFG_LATCH_R_INACT]);
  assign fire_any = fire_l | fire_r;

  // stop conditions
  logic stop_l;
  logic stop_r;
  logic stop_any;
  logic stop_entered;
  assign stop_l = l_act & switch_config_q[`RSL_CFG_STOP_L];
  assign stop_r = r_act & switch_config_q[`RSL_CFG_STOP_R];
  assign stop_any = stop_l | stop_r;
  assign stop_entered = (motion_q == RSL_RUN) && stop_any;

  logic rd_status;
  logic wr_config;
  logic wr_irq_status;
  logic wr_irq_mask;
  assign rd_status = i_read && (i_addr == `RSL_ADDR_STATUS);
  assign wr_config = i_write && (i_addr == `RSL_ADDR_CONFIG);
  assign wr_irq_status = i_write && (i_addr == `RSL_ADDR_IRQ_STATUS);
  assign wr_irq_mask = i_write && (i_addr == `RSL_ADDR_IRQ_MASK);

  // configuration register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      switch_config_q <= `RSL_CFG_RESET;
    end else if (wr_config) begin
      switch_config_q <= i_wdata[`RSL_CFG_WIDTH-1:0];
    end
  end

  // position latch, loaded when either side fires; both sides latch the same position
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      latched_position_q <= '0;
    end else if (fire_any) begin
      latched_position_q <= i_actual_position;
    end
  end

  // left latch-ready flag; a new event wins over the read clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      latch_l_q <= 1'b0;
    end else begin
      latch_l_q <= fire_l | (latch_l_q & ~rd_status);
    end
  end

  // right latch-ready flag; a new event wins over the read clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      latch_r_q <= 1'b0;
    end else begin
      latch_r_q <= fire_r | (latch_r_q & ~rd_status);
    end
  end

  // second move flag; a new event wins over the read clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      second_q <= 1'b0;
    end else begin
      second_q <= i_second_move_event | (second_q & ~rd_status);
    end
  end

  // motion state: stop while switch active, then zero wait, then resume
  logic zw_start;
  assign zw_start = (motion_q == RSL_STOPPED) && !stop_any;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      motion_q <= RSL_RUN;
    end else begin
      case (motion_q)
        RSL_RUN: begin
          if (stop_any) begin
            motion_q <= RSL_STOPPED;
          end
        end
        RSL_STOPPED: begin
          if (!stop_any) begin
            motion_q <= RSL_ZEROWAIT;
          end
        end
        RSL_ZEROWAIT: begin
          if (stop_any) begin
            motion_q <= RSL_STOPPED;
          end else if (!zw_active) begin
            motion_q <= RSL_RUN;
          end
        end
        default: motion_q <= RSL_RUN;
      endcase
    end
  end

  rsl_zero_wait #(
    .WAIT_WIDTH(WAIT_WIDTH)
  ) u_zero_wait (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_start(zw_start),
    .i_wait_cycles(i_zero_wait_cycles),
    .o_active(zw_active)
  );

  // hold request toward the ramp generator
  logic zw_busy;
  logic hold_d;
  assign zw_busy = (motion_q == RSL_ZEROWAIT) && (zw_active || zw_start);
  always_comb begin
    hold_d = stop_any | (motion_q == RSL_STOPPED) | zw_busy | ~i_motion_request;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // interrupt status, mask and output
  logic [`RSL_IRQ_WIDTH-1:0] irq_events;
  always_comb begin
    irq_events = '0;
    irq_events[`RSL_IRQ_LATCH_L] = fire_l;
    irq_events[`RSL_IRQ_LATCH_R] = fire_r;
    irq_events[`RSL_IRQ_SECOND] = i_second_move_event;
    irq_events[`RSL_IRQ_STOP] = stop_entered;
  end
  // next interrupt status: events set, a written one clears, set wins
  logic [`RSL_IRQ_WIDTH-1:0] irq_clear;
  logic [`RSL_IRQ_WIDTH-1:0] irq_status_d;
  always_comb begin
    irq_clear = '0;
    if (wr_irq_status) begin
      irq_clear = i_wdata[`RSL_IRQ_WIDTH-1:0];
    end
    irq_status_d = irq_events | (irq_status_q & ~irq_clear);
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_status_q <= `RSL_IRQ_RESET;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_mask_q <= `RSL_IRQ_RESET;
    end else if (wr_irq_mask) begin
      irq_mask_q <= i_wdata[`RSL_IRQ_WIDTH-1:0];
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_d & irq_mask_q);
    end
  end

  // status word
  logic [`RSL_ST_WIDTH-1:0] status;
  always_comb begin
    status = '0;
    status[`RSL_ST_STOP_L] = l_act;
    status[`RSL_ST_STOP_R] = r_act;
    status[`RSL_ST_LATCH_L] = latch_l_q;
    status[`RSL_ST_LATCH_R] = latch_r_q;
    status[`RSL_ST_EVT_STOP_L] = stop_l;
    status[`RSL_ST_EVT_STOP_R] = stop_r;
    status[`RSL_ST_ZEROWAIT] = zw_active;
    status[`RSL_ST_SECOND] = second_q;
    status[`RSL_ST_STALL] = i_stall_indication;
  end

  // read mux; zero unless a read strobe selects a register
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_read) begin
      case (i_addr)
        `RSL_ADDR_CONFIG: rdata_d = 32'(switch_config_q);
        `RSL_ADDR_STATUS: rdata_d = 32'(status);
        `RSL_ADDR_LATCH: rdata_d = 32'(latched_position_q);
        `RSL_ADDR_IRQ_STATUS: rdata_d = 32'(irq_status_q);
        `RSL_ADDR_IRQ_MASK: rdata_d = 32'(irq_mask_q);
        `RSL_ADDR_ACTUAL: rdata_d = 32'(i_actual_position);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // read data one cycle after the read strobe
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_motor_hold = hold_q;
  assign o_irq = irq_q;
endmodule // rsl_ref_switch

// [tb/rsl_ref_switch_properties.sv]
`timescale 1ns/1ps
`include "rsl_defines.svh"
module rsl_ref_switch_properties #(
  parameter int unsigned POS_WIDTH = 32,
  parameter int unsigned WAIT_WIDTH = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port
  input wire logic [2:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [31:0] o_rdata,
  // switches and ramp side
  input wire logic i_left_switch_in,
  input wire logic i_right_switch_in,
  input wire logic [POS_WIDTH-1:0] i_actual_position,
  input wire logic i_stall_indication,
  input wire logic i_second_move_event,
  input wire logic i_motion_request,
  input wire logic [WAIT_WIDTH-1:0] i_zero_wait_cycles,
  // motion and interrupt
  input wire logic o_motor_hold,
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_rdata_idle; !$past(i_read) |-> o_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  property p_actual; $past(i_read && i_addr == `RSL_ADDR_ACTUAL) |-> o_rdata == $past(i_actual_position);
  endproperty
  a_actual: assert property (p_actual) else $error("actual position read wrong");
  property p_stall; $past(i_read && i_addr == `RSL_ADDR_STATUS) |-> o_rdata[13] == $past(i_stall_indication);
  endproperty
  a_stall: assert property (p_stall) else $error("stall bit wrong");
  property p_spare; $past(i_read && i_addr == `RSL_ADDR_STATUS) |-> o_rdata[31:14] == 18'h0 && o_rdata[10:6] == 5'h0;
  endproperty
  a_spare: assert property (p_spare) else $error("unused status bits set");
  property p_second_clr;
    (i_read && i_addr == `RSL_ADDR_STATUS && !i_second_move_event) ##1
    (i_read && i_addr == `RSL_ADDR_STATUS && !i_second_move_event) |=> o_rdata[12] == 1'b0;
  endproperty
  a_second_clr: assert property (p_second_clr) else $error("second move not cleared by read");
  property p_cfg_back;
    (i_write && i_addr == `RSL_ADDR_CONFIG) ##1 !i_write ##1 (i_read && i_addr == `RSL_ADDR_CONFIG)
    |=> o_rdata[11:0] == $past(i_wdata[11:0], 3);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
  property p_irq_mask; (i_write && i_addr == `RSL_ADDR_IRQ_MASK && i_wdata[3:0] == 4'h0) ##1 !i_write [*2] |-> !o_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt high while masked");
  property p_no_move; !i_motion_request |=> o_motor_hold; endproperty
  a_no_move: assert property (p_no_move) else $error("motor not held without motion");
endmodule // rsl_ref_switch_properties

// [tb/rsl_switch_model.sv]
`timescale 1ns/1ps
module rsl_switch_model (
  // pressed state and wiring polarity
  input wire logic i_press_l,
  input wire logic i_press_r,
  input wire logic i_low_active_l,
  input wire logic i_low_active_r,
  // pin levels
  output logic o_left_pin,
  output logic o_right_pin
);
  // pressed drives the active level, released the opposite
  assign o_left_pin = i_press_l ^ i_low_active_l;
  assign o_right_pin = i_press_r ^ i_low_active_r;
endmodule // rsl_switch_model

// [tb/tb_rsl_ref_switch.sv]
`timescale 1ns/1ps
`include "rsl_defines.svh"
module tb_rsl_ref_switch;
  logic clk, rst, wr_en, rd_en, stall, second, mreq, hold, irq, lp, rp;
  logic [2:0] addr;
  logic [31:0] wdata, rdata, pos, f, l;
  logic [15:0] zw;
  logic [1:0] press, lowact;
  logic [6:0] rows [8];
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  rsl_switch_model i_sw (.i_press_l(press[0]), .i_press_r(press[1]), .i_low_active_l(lowact[0]),
    .i_low_active_r(lowact[1]), .o_left_pin(lp), .o_right_pin(rp));
  rsl_ref_switch i_dut (.i_core_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_write(wr_en),
    .i_read(rd_en), .o_rdata(rdata), .i_left_switch_in(lp), .i_right_switch_in(rp), .i_actual_position(pos),
    .i_stall_indication(stall), .i_second_move_event(second), .i_motion_request(mreq),
    .i_zero_wait_cycles(zw), .o_motor_hold(hold), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input int cnt);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    for (int k = 0; k < cnt; k++) begin
      @(posedge clk);
      if (k == cnt - 1) rd_en <= 1'b0;
      #1;
      if (k == 0) f = rdata;
      l = rdata;
    end
  endtask
  task latch(input logic [11:0] cfg, input int s, input logic v, input int fl, input logic [31:0] p);
    @(posedge clk);
    press[s] <= ~v;
    tick(4);
    wr(`RSL_ADDR_CONFIG, {20'h0, cfg});
    rd(`RSL_ADDR_STATUS, 1);
    @(posedge clk);
    pos <= p;
    press[s] <= v;
    tick(3);
    chk(irq, 1'b0);
    tick(3);
    @(posedge clk);
    pos <= p + 32'h1;
    rd(`RSL_ADDR_LATCH, 1);
    chk(f, p);
    rd(`RSL_ADDR_STATUS, 2);
    chk(f[fl], 1'b1);
    chk(l[fl], 1'b0);
  endtask
  task stop(input int s);
    wr(`RSL_ADDR_IRQ_STATUS, 32'hf);
    wr(`RSL_ADDR_IRQ_MASK, 32'h8);
    wr(`RSL_ADDR_CONFIG, 32'h1 << s);
    @(posedge clk);
    press[s] <= 1'b1;
    tick(5);
    chk(hold, 1'b1);
    chk(irq, 1'b1);
    rd(`RSL_ADDR_STATUS, 1);
    chk(f[`RSL_ST_EVT_STOP_L + s], 1'b1);
    @(posedge clk);
    press[s] <= 1'b0;
    tick(4);
    chk(hold, 1'b1);
    rd(`RSL_ADDR_STATUS, 1);
    chk(f[`RSL_ST_ZEROWAIT], 1'b1);
    n = 6;
    while (hold === 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk(hold, 1'b0);
    chk(n >= 10, 1'b1);
    wr(`RSL_ADDR_IRQ_MASK, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    wr(`RSL_ADDR_IRQ_STATUS, 32'hf);
    wr(`RSL_ADDR_IRQ_MASK, 32'hf);
    tick(2);
    chk(irq, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    {wr_en, rd_en, stall, second, addr, wdata, pos, press, lowact} = '0;
    mreq = 1'b1;
    zw = 16'ha;
    // swap, pol_l, pol_r, left pressed, right pressed, expected right and left active
    rows = '{7'h55, 7'h36, 7'h2f, 7'h10, 7'h4a, 7'h75, 7'h7a, 7'h4f};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`RSL_ADDR_CONFIG, 1);
    chk(f, 32'h0);
    rd(`RSL_ADDR_IRQ_MASK, 1);
    chk(f, 32'h0);
    chk(hold, 1'b0);
    foreach (rows[i]) begin
      @(posedge clk);
      press <= {rows[i][2], rows[i][3]};
      lowact <= rows[i][6] ? {rows[i][5], rows[i][4]} : {rows[i][4], rows[i][5]};
      wr(`RSL_ADDR_CONFIG, {27'h0, rows[i][6], rows[i][4], rows[i][5], 2'b00});
      tick(4);
      rd(`RSL_ADDR_STATUS, 1);
      chk(f[1:0], rows[i][1:0]);
    end
    @(posedge clk);
    press <= 2'b00;
    lowact <= 2'b00;
    wr(`RSL_ADDR_CONFIG, 32'h0);
    latch(12'h020, 0, 1'b1, `RSL_ST_LATCH_L, 32'h1234_5678);
    latch(12'h040, 0, 1'b0, `RSL_ST_LATCH_L, 32'h8000_0001);
    latch(12'h100, 1, 1'b0, `RSL_ST_LATCH_R, 32'h0bad_0001);
    latch(12'h080, 1, 1'b1, `RSL_ST_LATCH_R, 32'hfedc_ba98);
    wr(`RSL_ADDR_LATCH, 32'h0);
    rd(`RSL_ADDR_LATCH, 1);
    chk(f, 32'hfedc_ba98);
    rd(3'h6, 1);
    chk(f, 32'h0);
    rd(`RSL_ADDR_ACTUAL, 1);
    chk(f, 32'hfedc_ba99);
    @(posedge clk);
    press <= 2'b00;
    wr(`RSL_ADDR_CONFIG, 32'hf3c);
    rd(`RSL_ADDR_CONFIG, 1);
    chk(f, 32'hf3c);
    wr(`RSL_ADDR_CONFIG, 32'h0);
    stop(0);
    stop(1);
    @(posedge clk);
    zw <= 16'h0;
    wr(`RSL_ADDR_CONFIG, 32'h1);
    @(posedge clk);
    press[0] <= 1'b1;
    tick(5);
    chk(hold, 1'b1);
    @(posedge clk);
    press[0] <= 1'b0;
    tick(5);
    chk(hold, 1'b0);
    wr(`RSL_ADDR_IRQ_STATUS, 32'hf);
    @(posedge clk);
    stall <= 1'b1;
    rd(`RSL_ADDR_STATUS, 1);
    chk(f[`RSL_ST_STALL], 1'b1);
    @(posedge clk);
    stall <= 1'b0;
    second <= 1'b1;
    @(posedge clk);
    second <= 1'b0;
    rd(`RSL_ADDR_STATUS, 2);
    chk(f[`RSL_ST_STALL], 1'b0);
    chk(f[`RSL_ST_SECOND], 1'b1);
    chk(l[`RSL_ST_SECOND], 1'b0);
    chk(irq, 1'b1);
    @(posedge clk);
    mreq <= 1'b0;
    tick(2);
    chk(hold, 1'b1);
    end_sim;
  end
endmodule // tb_rsl_ref_switch
bind rsl_ref_switch rsl_ref_switch_properties #(.POS_WIDTH(POS_WIDTH), .WAIT_WIDTH(WAIT_WIDTH)) i_props (
  .i_core_clk, .i_reset, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata, .i_left_switch_in, .i_right_switch_in,
  .i_actual_position, .i_stall_indication, .i_second_move_event, .i_motion_request, .i_zero_wait_cycles,
  .o_motor_hold, .o_irq);
